// [logic/atdi_pkg.sv]
// Functional notes
// - Bit 15 of first register enables test
// - Test words replace conversion results during scans
// - Test scans use unity gain, zero offset
// - Calibration scans (code 011) ignore test enable
// - Automated balancing scans ignore test enable
// - Odd sample, first conversion uses word 1A
// - Odd sample, second conversion uses word 1B
// - Even sample, first conversion uses word 2A
// - Even sample, second conversion uses word 2B
// - Ratio code sets samples per acquisition
package atdi_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_TEST1A = 10'h067;
  localparam logic [9:0] IDX_TEST1B = 10'h068;
  localparam logic [9:0] IDX_TEST2A = 10'h069;
  localparam logic [9:0] IDX_TEST2B = 10'h06a;
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] ADDR_TEST1A = {IDX_TEST1A, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_TEST1B = {IDX_TEST1B, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_TEST2A = {IDX_TEST2A, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_TEST2B = {IDX_TEST2B, 2'b00};
  // Field layout
  localparam int WORD_W = 12;
  localparam int TEST_EN_BIT = 15;
  localparam logic TEST_EN_RST = 1'b0;
  localparam logic [WORD_W-1:0] WORD_RST = 12'h000;
  // Scan configuration and oversampling codes
  localparam logic [2:0] SCAN_CFG_CAL = 3'h3;
  localparam logic [2:0] OVS_SINGLE = 3'h0;
  localparam logic [2:0] OVS_X4 = 3'h1;
  localparam logic [2:0] OVS_BALANCE = 3'h3;
  localparam logic [7:0] CNT_SINGLE = 8'h01;
  localparam logic [7:0] CNT_X4 = 8'h04;
  localparam logic [7:0] CNT_MAX = 8'h80;
  // Calibration neutral values
  localparam int GAIN_W = 16;
  localparam logic [GAIN_W-1:0] GAIN_UNITY = 16'h8000;
  localparam logic [GAIN_W-1:0] OFFSET_ZERO = 16'h0000;
  // Conversion phase within one sample
  typedef enum logic [1:0] {
    CONV_FIRST = 2'b01,
    CONV_SECOND = 2'b10
  } atdi_conv_t;

  // Samples per acquisition for a ratio code
  function automatic logic [7:0] ratio_count(input logic [2:0] code);
    logic [7:0] cnt;
    cnt = CNT_MAX;
    if (code == OVS_SINGLE) begin
      cnt = CNT_SINGLE;
    end else if (code == OVS_X4) begin
      cnt = CNT_X4;
    end else if (code[2:1] != 2'b11) begin
      cnt = CNT_X4 << (code - OVS_X4);
    end
    return cnt;
  endfunction
endpackage

// [logic/atdi_top.sv]
// The APB slave port is this design's own decision.
`timescale 1ns/100ps
module atdi_top #(
  parameter int DATA_W = atdi_pkg::WORD_W,
  parameter int GAIN_W = atdi_pkg::GAIN_W
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [atdi_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Scan context from the sequencer
  input wire logic scan_start,
  input wire logic [2:0] scan_config_select,
  input wire logic [2:0] oversample_ratio,
  input wire logic auto_balance,
  // Conversion results from the converter
  input wire logic conv_valid,
  input wire logic [DATA_W-1:0] conv_data,
  // Calibration coefficients from trim storage
  input wire logic [GAIN_W-1:0] cal_gain_in,
  input wire logic [GAIN_W-1:0] cal_offset_in,
  // Toward the arithmetic unit
  output logic alu_valid,
  output logic [DATA_W-1:0] alu_data,
  output logic [GAIN_W-1:0] cal_gain,
  output logic [GAIN_W-1:0] cal_offset,
  output logic test_active
);
  logic alu_test_enable_ff;
  logic [DATA_W-1:0] odd_first_test_word_ff;
  logic [DATA_W-1:0] odd_second_test_word_ff;
  logic [DATA_W-1:0] even_first_test_word_ff;
  logic [DATA_W-1:0] even_second_test_word_ff;
  logic [31:0] prdata_ff;
  logic alu_valid_ff;
  logic [DATA_W-1:0] alu_data_ff;
  logic [GAIN_W-1:0] cal_gain_ff;
  logic [GAIN_W-1:0] cal_offset_ff;
  logic test_active_ff;
  logic [DATA_W-1:0] nxt_alu_data;
  logic [2:0] ratio_eff;
  atdi_trk_if trk ();

  // Address decode
  wire hit_1a = (paddr == atdi_pkg::ADDR_TEST1A);
  wire hit_1b = (paddr == atdi_pkg::ADDR_TEST1B);
  wire hit_2a = (paddr == atdi_pkg::ADDR_TEST2A);
  wire hit_2b = (paddr == atdi_pkg::ADDR_TEST2B);
  wire hit_any = hit_1a | hit_1b | hit_2a | hit_2b;
  wire setup = psel & ~penable;
  wire wr_en = psel & penable & pwrite;

  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;
  assign prdata = prdata_ff;

  wire [31:0] rd_mux =
    hit_1a ? {16'h0000, alu_test_enable_ff, 3'h0, odd_first_test_word_ff} :
    hit_1b ? {20'h0000_0, odd_second_test_word_ff} :
    hit_2a ? {20'h0000_0, even_first_test_word_ff} :
    hit_2b ? {20'h0000_0, even_second_test_word_ff} : 32'h0000_0000;

  // Read data is captured in the setup phase so it is stable during access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata_ff <= rd_mux;
    end
  end

  // enable flag and reset to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alu_test_enable_ff <= atdi_pkg::TEST_EN_RST;
      odd_first_test_word_ff <= atdi_pkg::WORD_RST;
    end else if (wr_en && hit_1a) begin
      alu_test_enable_ff <= pwdata[atdi_pkg::TEST_EN_BIT];
      odd_first_test_word_ff <= pwdata[DATA_W-1:0];
    end
  end

  // only the low word bits are stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      odd_second_test_word_ff <= atdi_pkg::WORD_RST;
      even_first_test_word_ff <= atdi_pkg::WORD_RST;
      even_second_test_word_ff <= atdi_pkg::WORD_RST;
    end else if (wr_en) begin
      if (hit_1b) begin
        odd_second_test_word_ff <= pwdata[DATA_W-1:0];
      end
      if (hit_2a) begin
        even_first_test_word_ff <= pwdata[DATA_W-1:0];
      end
      if (hit_2b) begin
        even_second_test_word_ff <= pwdata[DATA_W-1:0];
      end
    end
  end

  // calibration scans and balancing scans use real data
  wire cal_scan = (scan_config_select == atdi_pkg::SCAN_CFG_CAL);
  wire subst = alu_test_enable_ff & ~cal_scan & ~auto_balance;

  // ratio is forced in calibration and balancing scans
  assign ratio_eff = cal_scan ? atdi_pkg::OVS_SINGLE :
                     auto_balance ? atdi_pkg::OVS_BALANCE : oversample_ratio;

  atdi_track u_track (
    .pclk(pclk),
    .presetn(presetn),
    .scan_start(scan_start),
    .conv_valid(conv_valid),
    .ratio_code(ratio_eff),
    .trk(trk)
  );

  // pick word by sample parity and conversion
  wire [DATA_W-1:0] odd_word = trk.second_conv ? odd_second_test_word_ff
                                               : odd_first_test_word_ff;
  wire [DATA_W-1:0] even_word = trk.second_conv ? even_second_test_word_ff
                                                : even_first_test_word_ff;
  wire [DATA_W-1:0] test_word = trk.odd_sample ? odd_word : even_word;
  assign nxt_alu_data = subst ? test_word : conv_data;

  // Result to the arithmetic unit, one cycle after the conversion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alu_valid_ff <= 1'b0;
      alu_data_ff <= atdi_pkg::WORD_RST;
    end else begin
      alu_valid_ff <= conv_valid;
      if (conv_valid) begin
        alu_data_ff <= nxt_alu_data;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_gain_ff <= atdi_pkg::GAIN_UNITY;
      cal_offset_ff <= atdi_pkg::OFFSET_ZERO;
      test_active_ff <= 1'b0;
    end else begin
      cal_gain_ff <= subst ? atdi_pkg::GAIN_UNITY : cal_gain_in;
      cal_offset_ff <= subst ? atdi_pkg::OFFSET_ZERO : cal_offset_in;
      test_active_ff <= subst;
    end
  end

  assign alu_valid = alu_valid_ff;
  assign alu_data = alu_data_ff;
  assign cal_gain = cal_gain_ff;
  assign cal_offset = cal_offset_ff;
  assign test_active = test_active_ff;
endmodule

// [logic/atdi_track.sv]
`timescale 1ns/100ps
module atdi_track (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Scan events
  input wire logic scan_start,
  input wire logic conv_valid,
  input wire logic [2:0] ratio_code,
  // Position out
  atdi_trk_if.src trk
);
  atdi_pkg::atdi_conv_t phase_ff;
  atdi_pkg::atdi_conv_t nxt_phase;
  logic [7:0] smp_ff;
  logic [7:0] nxt_smp;
  logic [7:0] smp_total;
  logic last_smp;

  assign smp_total = atdi_pkg::ratio_count(ratio_code);
  assign last_smp = (smp_ff + 8'h01) >= smp_total;
  // Sample index counts from zero, so index zero is the first, odd sample
  assign trk.odd_sample = ~smp_ff[0];
  assign trk.second_conv = (phase_ff == atdi_pkg::CONV_SECOND);

  // Next phase and sample; wraps so every channel starts at an odd sample
  always_comb begin
    nxt_phase = phase_ff;
    nxt_smp = smp_ff;
    if (scan_start) begin
      nxt_phase = atdi_pkg::CONV_FIRST;
      nxt_smp = 8'h00;
    end else if (conv_valid) begin
      case (phase_ff)
        atdi_pkg::CONV_FIRST: begin
          nxt_phase = atdi_pkg::CONV_SECOND;
        end
        atdi_pkg::CONV_SECOND: begin
          nxt_phase = atdi_pkg::CONV_FIRST;
          nxt_smp = last_smp ? 8'h00 : smp_ff + 8'h01;
        end
        default: begin
          nxt_phase = atdi_pkg::CONV_FIRST;
          nxt_smp = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_ff <= atdi_pkg::CONV_FIRST;
      smp_ff <= 8'h00;
    end else begin
      phase_ff <= nxt_phase;
      smp_ff <= nxt_smp;
    end
  end
endmodule

// [logic/atdi_trk_if.sv]
`timescale 1ns/100ps
// Position of the current conversion inside the acquisition
interface atdi_trk_if;
  logic second_conv;
  logic odd_sample;
  modport src (output second_conv, output odd_sample);
  modport dst (input second_conv, input odd_sample);
endinterface

// [tb/alu_test_data_injection_bench.sv]
`timescale 1ns/100ps
module alu_test_data_injection_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic scan_start = 0, auto_balance = 0, conv_valid = 0;
  logic [11:0] paddr = 0, conv_data = 0, alu_data;
  logic [31:0] pwdata = 0, prdata, v;
  logic [2:0] scan_config_select = 0, oversample_ratio = 0;
  logic [15:0] cal_gain_in = 0, cal_offset_in = 0, cal_gain, cal_offset;
  logic pready, pslverr, alu_valid, test_active;
  logic [11:0] wd [4];
  logic [31:0] aq [$], rq [$];
  int num_errors = 0, checked = 0, c, k, n;
  atdi_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .scan_start, .scan_config_select, .oversample_ratio,
    .auto_balance, .conv_valid, .conv_data, .cal_gain_in, .cal_offset_in, .alu_valid,
    .alu_data, .cal_gain, .cal_offset, .test_active);
  // Free-running 100 MHz clock
  initial begin
    forever #5 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected at %0t: saw %h, want %h", $time, s, e);
    end
  endtask
  task automatic give_verdict;
    if (num_errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  function automatic logic [11:0] ad(input int i);
    return atdi_pkg::ADDR_TEST1A + 12'(4 * i);
  endfunction
  // One APB transfer; for a read, d is the word expected back
  task automatic ap(input bit w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) rq.push_back(d);
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic st;
    @(posedge pclk);
    scan_start <= 1'b1;
    @(posedge pclk);
    scan_start <= 1'b0;
  endtask
  // One conversion; t says whether the test word e should replace it
  task automatic cv(input bit t, input logic [11:0] e);
    logic [11:0] d;
    d = 12'($urandom);
    @(posedge pclk);
    conv_valid <= 1'b1;
    conv_data <= d;
    aq.push_back(t ? e : d);
    @(posedge pclk);
    conv_valid <= 1'b0;
    chk(test_active, t);
    chk(cal_gain, t ? 16'h8000 : cal_gain_in);
    chk(cal_offset, t ? 16'h0000 : cal_offset_in);
  endtask
  // Results and read data are matched in order against the notes
  always @(posedge pclk) begin
    if (alu_valid === 1'b1) chk(alu_data, aq.pop_front());
    if (psel && penable && !pwrite) chk(prdata, rq.pop_front());
    if (psel && penable) chk(pslverr, paddr > atdi_pkg::ADDR_TEST2B);
  end
  // Generous limit; the whole run needs about seventeen hundred cycles
  initial begin
    #300000;
    num_errors++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'h6921_4d48));
    cal_gain_in <= 16'($urandom);
    cal_offset_in <= 16'($urandom);
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, masks and the unmapped slot
    for (c = 0; c < 5; c++) ap(0, ad(c), 0);
    for (c = 0; c < 4; c++) begin
      v = $urandom | 32'hffff_f000;
      wd[c] = v[11:0];
      ap(1, ad(c), v);
      ap(0, ad(c), v & (c ? 32'h0000_0fff : 32'h0000_8fff));
    end
    ap(1, ad(4), 32'hffff_ffff);
    ap(0, ad(4), 0);
    // word order for every ratio code, past the wrap
    for (c = 0; c < 8; c++) begin
      n = c == 0 ? 1 : (c > 5 ? 128 : 4 << (c - 1));
      oversample_ratio <= 3'(c);
      st();
      for (k = 0; k < 2 * n + 2; k++) cv(1, wd[((k / 2) % n) % 2 * 2 + k % 2]);
    end
    // real data for calibration, balancing and disabled test
    scan_config_select <= 3'h3;
    st();
    repeat (3) cv(0, 0);
    scan_config_select <= 3'h0;
    auto_balance <= 1'b1;
    st();
    repeat (3) cv(0, 0);
    auto_balance <= 1'b0;
    ap(1, ad(0), 0);
    st();
    repeat (3) cv(0, 0);
    repeat (4) @(posedge pclk);
    // A lost result or read would otherwise leave its note unchecked
    chk(aq.size(), 0);
    chk(rq.size(), 0);
    give_verdict();
  end
endmodule

// [tb/atdi_assertions.sv]
`timescale 1ns/100ps
module atdi_assertions (
  // Clock, reset and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Data path
  input wire logic [2:0] scan_config_select,
  input wire logic auto_balance,
  input wire logic conv_valid,
  input wire logic [11:0] conv_data,
  input wire logic alu_valid,
  input wire logic [11:0] alu_data,
  input wire logic [15:0] cal_gain,
  input wire logic [15:0] cal_offset,
  input wire logic test_active,
  // Coefficients from trim storage
  input wire logic [15:0] cal_gain_in,
  input wire logic [15:0] cal_offset_in
);
  // Mapped words are four aligned indices in a row
  wire [9:0] idx = paddr[11:2];
  wire hit = paddr[1:0] == 2'b00 && idx >= atdi_pkg::IDX_TEST1A && idx <= atdi_pkg::IDX_TEST2B;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_valid_lag: assert property (conv_valid |=> alu_valid)
    else $error("result pulse missing");
  a_valid_once: assert property (!conv_valid |=> !alu_valid)
    else $error("stray result pulse");
  a_data_hold: assert property (!conv_valid |=> $stable(alu_data))
    else $error("result moved without conversion");
  a_cal_real: assert property (
    conv_valid && scan_config_select == 3'h3 |=> alu_data == $past(conv_data))
    else $error("calibration scan not real");
  a_bal_real: assert property (
    conv_valid && auto_balance |=> alu_data == $past(conv_data))
    else $error("balancing scan not real");
  a_unity_cal: assert property (
    test_active && $past(test_active) |-> cal_gain == 16'h8000 && cal_offset == 16'h0000)
    else $error("coefficients not neutral");
  // Outside test mode the trim values pass through; the first cycle after reset is skipped
  a_cal_pass: assert property (
    !test_active && $past(presetn) |->
      cal_gain == $past(cal_gain_in) && cal_offset == $past(cal_offset_in))
    else $error("coefficients not passed through");
  a_unmapped_err: assert property (psel && penable |-> pslverr == !hit)
    else $error("error flag wrong");
  a_upper_zero: assert property (prdata[31:16] == 16'h0000 && prdata[14:12] == 3'h0)
    else $error("unused bits not zero");
endmodule

bind atdi_top atdi_assertions u_chk (.pclk, .presetn, .psel, .penable, .paddr, .prdata,
  .pslverr, .scan_config_select, .auto_balance, .conv_valid, .conv_data, .alu_valid,
  .alu_data, .cal_gain, .cal_offset, .test_active, .cal_gain_in, .cal_offset_in);
